// file: inc/lfcp_map.svh
// lfcp_map.svh: field widths, reset values and counts for the lcd frame clock
// and pin block; assumes nothing beyond a plain systemverilog compiler.
`ifndef LFCP_MAP_SVH
`define LFCP_MAP_SVH
// ==========================================================================
// divider figures
`define LFCP_BASE_DIV       16
`define LFCP_FRM_SEL_W      4
`define LFCP_DUTY_SEL_W     3
`define LFCP_FRM_SEL_RST    4'h0
`define LFCP_DUTY_SEL_RST   3'h0
// ==========================================================================
// pin group sizes
`define LFCP_COM_LOW_N      4
`define LFCP_SHARED_N       4
`define LFCP_SEG_MID_N      20
// duty select value from which the shared pins become commons (1/5 duty)
`define LFCP_DUTY_SHARED_COM 3'h4
`endif

// file: inc/lfcp_pkg.sv
// lfcp_pkg.sv: types for the lcd frame clock and pin block.
// assumes lfcp_map.svh is on the include path.
`include "lfcp_map.svh"
package lfcp_pkg;
   // ==========================================================================
   // configuration carried as one word
   typedef struct packed {
      logic                         drv_en;
      logic                         discharge_enable;
      logic                         debug_run;
      logic [`LFCP_FRM_SEL_W-1:0]   frame_divider_select;
      logic [`LFCP_DUTY_SEL_W-1:0]  duty_select;
   } lfcp_cfg_t;
   // electrode drive values and enables
   typedef struct packed {
      logic [`LFCP_COM_LOW_N-1:0]   com_low;
      logic [`LFCP_SHARED_N-1:0]    shared;
      logic [`LFCP_SEG_MID_N-1:0]   seg_mid;
   } lfcp_pins_t;
   typedef enum logic [1:0] {LFCP_IDLE, LFCP_RUN, LFCP_HALT} lfcp_state_t;
endpackage

// file: verilog/lfcp_frame_div.sv
// lfcp_frame_div.sv: frame divider counting core-clock ticks.
// assumes core_tick_i is a one-cycle pulse per core clock period.
`timescale 1ns/1ps
`include "lfcp_map.svh"
module lfcp_frame_div #(
   parameter int FRM_W  = 4,
   parameter int DUTY_W = 3
) (
   // clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   // control
   input  wire logic              run_i,
   input  wire logic              core_tick_i,
   input  wire logic [FRM_W-1:0]  frame_divider_select_i,
   input  wire logic [DUTY_W-1:0] duty_select_i,
   // frame pulse
   output logic                   frame_pulse_o
);
   localparam int CNT_W = 4 + FRM_W + DUTY_W;
   // ==========================================================================
   // terminal count is 16*(frm+1)*(duty+1)-1
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] terminal;
   wire              at_end;
   assign terminal = CNT_W'(`LFCP_BASE_DIV * (32'(frame_divider_select_i) + 32'd1)
                     * (32'(duty_select_i) + 32'd1) - 32'd1);
   assign at_end   = (cnt >= terminal);
   // counter holds its value while halted, so a resume picks up where it stood
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt           <= '0;
         frame_pulse_o <= 1'b0;
      end
      else
      begin
         frame_pulse_o <= run_i & core_tick_i & at_end;
         if (run_i && core_tick_i)
            cnt <= at_end ? '0 : cnt + CNT_W'(1);
      end
   end
endmodule

// file: verilog/lfcp_top.sv
// lfcp_top.sv: lcd frame timing and electrode pin control.
// assumes the core clock arrives as a one-cycle tick on core_tick_i, about 32 kHz,
// and that waveform data for each electrode comes from the drive generator.
//
// Functional notes
// - frame = core / (16*(frm+1)*(duty+1))
// - debug without debug run halts, display off
// - leaving debug restores clock, operation resumes
// - registers hold their values during debug halt; pin_o drops to 0 and pin_oe_o follows discharge_enable while halted
// - debug run keeps display running in debug
// - shared pins are commons or segments by duty
// - assigned pins drive low if discharge enabled
// - frame monitor output starts low
// - duty select offers 1/8 to static
`timescale 1ns/1ps
`include "lfcp_map.svh"
module lfcp_top (
   // clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 rst_n_i,
   // core clock tick and debug state
   input  wire logic                 core_tick_i,
   input  wire logic                 cpu_debug_i,
   // configuration
   input  wire lfcp_pkg::lfcp_cfg_t  cfg_i,
   // waveform levels from the drive generator
   input  wire lfcp_pkg::lfcp_pins_t wave_i,
   // electrode pins
   output lfcp_pkg::lfcp_pins_t      pin_o,
   output lfcp_pkg::lfcp_pins_t      pin_oe_o,
   output logic [`LFCP_SHARED_N-1:0] shared_is_com_o,
   // frame monitor and status
   output logic                      frame_monitor_out_o,
   output logic                      frame_pulse_o,
   output logic                      display_on_o,
   output lfcp_pkg::lfcp_state_t     state_o
);
   // ==========================================================================
   // state decode
   lfcp_pkg::lfcp_state_t state;
   lfcp_pkg::lfcp_state_t next_state;
   wire halt_req;
   wire run;
   wire shared_com;
   assign halt_req = cpu_debug_i & ~cfg_i.debug_run;
   assign run      = (state == lfcp_pkg::LFCP_RUN);
   // duty 1/5..1/8 needs commons 4-7, shorter duties use them as segments
   assign shared_com = (cfg_i.duty_select >= `LFCP_DUTY_SHARED_COM);

   // state machine: halt freezes the divider count, nothing is reset by debug
   always_comb
   begin
      next_state = state;
      case (state)
         lfcp_pkg::LFCP_IDLE:
            if (cfg_i.drv_en && !halt_req)
               next_state = lfcp_pkg::LFCP_RUN;
         lfcp_pkg::LFCP_RUN:
            if (!cfg_i.drv_en)
               next_state = lfcp_pkg::LFCP_IDLE;
            else if (halt_req)
               next_state = lfcp_pkg::LFCP_HALT;
         lfcp_pkg::LFCP_HALT:
            if (!halt_req)
               next_state = cfg_i.drv_en ? lfcp_pkg::LFCP_RUN
                                         : lfcp_pkg::LFCP_IDLE;
         default:
            next_state = lfcp_pkg::LFCP_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state <= lfcp_pkg::LFCP_IDLE;
      else
         state <= next_state;
   end

   // ==========================================================================
   // frame divider
   wire frame_pulse;
   lfcp_frame_div #(
      .FRM_W  (`LFCP_FRM_SEL_W),
      .DUTY_W (`LFCP_DUTY_SEL_W)
   ) u_div (
      .mclk_i                 (mclk_i),
      .rst_n_i                (rst_n_i),
      .run_i                  (run),
      .core_tick_i            (core_tick_i),
      .frame_divider_select_i (cfg_i.frame_divider_select),
      .duty_select_i          (cfg_i.duty_select),
      .frame_pulse_o          (frame_pulse)
   );
   assign frame_pulse_o = frame_pulse;

   // frame monitor toggles per frame, low while idle, holds its level while halted
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         frame_monitor_out_o <= 1'b0;
      else if (state == lfcp_pkg::LFCP_IDLE)
         frame_monitor_out_o <= 1'b0;
      else if (frame_pulse)
         frame_monitor_out_o <= ~frame_monitor_out_o;
   end

   // ==========================================================================
   // pin drive: data from flops; low when not displaying with discharge
   lfcp_pkg::lfcp_pins_t next_pin;
   lfcp_pkg::lfcp_pins_t next_oe;
   assign next_pin = run ? wave_i : '0;
   assign next_oe  = (run || cfg_i.discharge_enable) ? '1 : '0;

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_o           <= '0;
         pin_oe_o        <= '0;
         shared_is_com_o <= '0;
      end
      else
      begin
         pin_o           <= next_pin;
         pin_oe_o        <= next_oe;
         shared_is_com_o <= {`LFCP_SHARED_N{shared_com}};
      end
   end

   assign display_on_o = run;
   assign state_o      = state;

   // ==========================================================================
   // checks
   sequence s_halted;
      state == lfcp_pkg::LFCP_HALT;
   endsequence

   property p_debug_halts;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (run && halt_req && cfg_i.drv_en) |=> s_halted;
   endproperty
   a_debug_halts: assert property (p_debug_halts)
      else $error("debug entry did not halt");

   property p_resume;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (s_halted and !halt_req && cfg_i.drv_en) |=> run;
   endproperty
   a_resume: assert property (p_resume)
      else $error("no resume after debug");

   property p_no_pulse_halted;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_halted ##1 s_halted |-> !frame_pulse;
   endproperty
   a_no_pulse_halted: assert property (p_no_pulse_halted)
      else $error("frame pulse while halted");

   property p_debug_run;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (run && cpu_debug_i && cfg_i.debug_run && cfg_i.drv_en) |=> run;
   endproperty
   a_debug_run: assert property (p_debug_run)
      else $error("display stopped with debug run set");

   property p_shared_route;
      @(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> shared_is_com_o[0] == ($past(cfg_i.duty_select) >= 3'h4);
   endproperty
   a_shared_route: assert property (p_shared_route)
      else $error("shared pin routing wrong");

   property p_discharge_low;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!run && cfg_i.discharge_enable) |=> (pin_o == '0) && (pin_oe_o == '1);
   endproperty
   a_discharge_low: assert property (p_discharge_low)
      else $error("idle pins not driven low");

   property p_monitor_low;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (state == lfcp_pkg::LFCP_IDLE) |=> !frame_monitor_out_o;
   endproperty
   a_monitor_low: assert property (p_monitor_low)
      else $error("frame monitor not low when idle");

   property p_monitor_toggle;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (frame_pulse && state != lfcp_pkg::LFCP_IDLE)
         |=> frame_monitor_out_o != $past(frame_monitor_out_o);
   endproperty
   a_monitor_toggle: assert property (p_monitor_toggle)
      else $error("frame monitor missed a frame");

   // shortest frame is 16 core ticks, so two pulses never sit within 8 cycles
   property p_static_period;
      @(posedge mclk_i) disable iff (!rst_n_i)
      frame_pulse |=> (!frame_pulse) [*8];
   endproperty
   a_static_period: assert property (p_static_period)
      else $error("frame pulses too close");
endmodule

// file: tb/lfcp_panel.sv
// lfcp_panel.sv: passive panel model resolving the level seen on each electrode.
// assumes pin_i and pin_oe_i come straight from the block's electrode outputs.
`timescale 1ns/1ps
module lfcp_panel (
   // clock
   input  wire logic                 mclk_i,
   // electrode drive and enables
   input  wire lfcp_pkg::lfcp_pins_t pin_i,
   input  wire lfcp_pkg::lfcp_pins_t pin_oe_i,
   // level seen at the panel
   output lfcp_pkg::lfcp_pins_t      level_o
);
   // ==========================================================================
   // floating electrodes drift: shown as the inverse of the last level,
   // so a released pin never passes for a steady value
   lfcp_pkg::lfcp_pins_t last = '0;
   always @(posedge mclk_i) last <= level_o;
   assign level_o = (pin_i & pin_oe_i) | (~last & ~pin_oe_i);
endmodule

// file: tb/lfcp_top_tb_top.sv
// lfcp_top_tb_top.sv: self-checking bench for the frame clock and pin block.
// assumes lfcp_pkg, lfcp_top and lfcp_panel are compiled before this file.
`timescale 1ns/1ps
module lfcp_top_tb_top;
   // ==========================================================================
   // signals
   logic                  mclk_i, rst_n_i, core_tick_i, cpu_debug_i, tick_gate, cnt_en;
   logic                  frame_monitor_out_o, frame_pulse_o, display_on_o, mon_exp, mon_due;
   logic [3:0]            shared_is_com_o;
   lfcp_pkg::lfcp_cfg_t   cfg_i;
   lfcp_pkg::lfcp_pins_t  wave_i, pin_o, pin_oe_o, level;
   lfcp_pkg::lfcp_state_t state_o;
   int                    fail_count, cmp_count, n;
   int                    exp_q[$];
   logic [31:0]           lfsr;
   // block and panel
   lfcp_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .core_tick_i(core_tick_i),
      .cpu_debug_i(cpu_debug_i), .cfg_i(cfg_i), .wave_i(wave_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .shared_is_com_o(shared_is_com_o),
      .frame_monitor_out_o(frame_monitor_out_o), .frame_pulse_o(frame_pulse_o),
      .display_on_o(display_on_o), .state_o(state_o));
   lfcp_panel i_panel (.mclk_i(mclk_i), .pin_i(pin_o), .pin_oe_i(pin_oe_o), .level_o(level));
   // 4 ns clock
   initial
   begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   // core clock compressed to every other cycle, else a frame takes minutes
   always @(posedge mclk_i) core_tick_i <= tick_gate & ~core_tick_i;
   // ==========================================================================
   // watcher: counts ticks per frame, takes the oldest note at each pulse
   always @(posedge mclk_i)
   begin
      if (mon_due)
         check(frame_monitor_out_o, mon_exp);
      mon_due = 1'b0;
      if (frame_pulse_o === 1'b1)
      begin
         if (exp_q.size() > 0)
            check(n, exp_q.pop_front());
         n = 0;
         mon_exp = ~mon_exp;
         mon_due = 1'b1;
      end
      if (core_tick_i && cnt_en)
         n++;
   end
   // ==========================================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] next_lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_i);
   endtask
   // bounded wait for the next frame pulse
   task automatic wait_pulse();
      int i;
      i = 0;
      do
      begin
         @(posedge mclk_i);
         i++;
      end
      while (frame_pulse_o !== 1'b1 && i < 5000);
      if (i >= 5000)
      begin
         fail_count++;
         print_verdict();
      end
   endtask
   // first pulse resyncs after the change, the second is a full frame
   task automatic measure(input logic [3:0] f, input logic [2:0] d);
      cfg_i.frame_divider_select <= f;
      cfg_i.duty_select <= d;
      wait_pulse();
      cyc(1);
      exp_q.push_back(16 * (int'(f) + 1) * (int'(d) + 1));
      wait_pulse();
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================================================
   // main sequence
   initial
   begin
      rst_n_i = 1'b0;
      cpu_debug_i = 1'b0;
      tick_gate = 1'b0;
      cnt_en = 1'b1;
      cfg_i = '0;
      cfg_i.discharge_enable = 1'b1;
      wave_i = '0;
      {fail_count, cmp_count, n} = '0;
      {mon_exp, mon_due} = 2'h0;
      lfsr = 32'h000139AF;
      cyc(20);
      rst_n_i <= 1'b1;
      cyc(3);
      check(pin_oe_o, 32'h0FFFFFFF);
      check(pin_o, 32'h0);
      check(frame_monitor_out_o, 32'h0);
      cfg_i.discharge_enable <= 1'b0;
      cyc(3);
      check(pin_oe_o, 32'h0);
      cfg_i.discharge_enable <= 1'b1;
      wave_i <= lfsr[27:0];
      cyc(2);
      cfg_i.drv_en <= 1'b1;
      for (int d = 0; d < 8; d++)
      begin
         cfg_i.duty_select <= d[2:0];
         cyc(3);
         check(shared_is_com_o, d > 3 ? 32'hF : 32'h0);
      end
      check(level, wave_i);
      $display("test pins done");
      tick_gate <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         lfsr = next_lfsr(lfsr);
         measure(k == 0 ? 4'h0 : k == 1 ? 4'hF : lfsr[3:0],
                 k == 0 ? 3'h0 : k == 1 ? 3'h7 : lfsr[6:4]);
      end
      $display("test frame done");
      measure(4'h0, 3'h0);
      cyc(1);
      exp_q.push_back(16);
      cyc(9);
      tick_gate <= 1'b0;
      cyc(3);
      cpu_debug_i <= 1'b1;
      cyc(3);
      check(state_o, lfcp_pkg::LFCP_HALT);
      check(display_on_o, 32'h0);
      check(pin_o, 32'h0);
      cnt_en = 1'b0;
      tick_gate <= 1'b1;
      cyc(40);
      tick_gate <= 1'b0;
      cyc(3);
      cnt_en = 1'b1;
      cpu_debug_i <= 1'b0;
      cyc(3);
      check(state_o, lfcp_pkg::LFCP_RUN);
      tick_gate <= 1'b1;
      wait_pulse();
      $display("test debug halt done");
      cfg_i.debug_run <= 1'b1;
      cpu_debug_i <= 1'b1;
      cyc(1);
      exp_q.push_back(16);
      wait_pulse();
      check(display_on_o, 32'h1);
      cpu_debug_i <= 1'b0;
      cyc(2);
      $display("test debug run done");
      // halt, then leave debug with the driver switched off: back to idle
      tick_gate <= 1'b0;
      cfg_i.debug_run <= 1'b0;
      cpu_debug_i <= 1'b1;
      cyc(3);
      cfg_i.drv_en <= 1'b0;
      cpu_debug_i <= 1'b0;
      cyc(3);
      check(state_o, lfcp_pkg::LFCP_IDLE);
      check(frame_monitor_out_o, 32'h0);
      check(pin_oe_o, 32'h0FFFFFFF);
      check(pin_o, 32'h0);
      $display("test driver off done");
      print_verdict();
   end
endmodule
